// file: ict_timing.sv
`timescale 1ns/1ps
`default_nettype none
module ict_timing
  import ict_pkg::*;
(
  input  wire logic        clk,            // core clock, 40 MHz
  input  wire logic        rst_n,          // async reset, active low
  input  wire logic        word_valid,     // fetched word present this cycle
  input  wire logic [23:0] word_data,      // fetched program word
  input  wire logic        is_double,      // decoded first word of a double-word op
  input  wire logic        is_skip,        // decoded skip instruction
  input  wire logic        cond_true,      // conditional test true
  input  wire logic        pc_change,      // instruction changes program counter
  input  wire logic        program_space_visibility_access, // program-space or table read
  input  wire logic        special_function_register,      // special register read
  input  wire logic        next_is_double, // instruction after skip is two-word
  input  wire logic        byte_mode,      // literal operand in byte mode
  input  wire logic [9:0]  ten_bit_unsigned_literal, // raw literal field
  input  wire logic [3:0]  bit_position_selector,    // raw bit field
  input  wire logic        writeback_indirect, // write-back to the pointed word, then add two
  input  wire logic [15:0] working_register_thirteen, // current register thirteen
  output logic             exec_q,         // real execute cycle
  output logic             nop_q,          // no-op cycle, no side effects
  output logic             instr_done_q,   // final cycle of an instruction
  output logic [47:0]      dbl_word_q,     // assembled double-word instruction
  output logic             dbl_valid_q,    // dbl_word_q valid pulse
  output logic             second_bad_q,   // second word had non-zero top bits
  output logic [9:0]       lit_q,          // range-limited literal
  output logic             lit_err_q,      // literal exceeded mode range
  output logic [15:0]      bit_mask_q,     // one-hot selected bit
  output logic             writeback_mem_q,  // write-back goes to memory
  output logic [15:0]      writeback_addr_q, // write-back address
  output logic [15:0]      wreg13_next_q     // register thirteen after write-back
);
  ict_state_t  state_q;
  logic [1:0]  extra_q;
  logic [23:0] first_q;
  logic        hi_zero;
  logic [1:0]  single_cycles;
  logic [9:0]  lit_max;

  assign hi_zero = (word_data[WORD_W-1:HI_ZERO_LSB] == '0); // RULE_02
  assign lit_max = byte_mode ? LIT_BYTE_MAX : LIT_WORD_MAX; // RULE_10

  // cycle count for a single-word op; skip cost wins since it also changes flow
  always_comb begin
    single_cycles = CYC_ONE; // RULE_05
    if (is_skip && cond_true) begin
      single_cycles = next_is_double ? CYC_THREE : CYC_TWO; // RULE_08
    end else if (cond_true || pc_change || program_space_visibility_access ||
                 special_function_register) begin
      single_cycles = CYC_TWO; // RULE_06
    end
  end

  // sequencing: operand consumption and fill cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= ICT_DECODE;
      extra_q      <= 2'h0;
      first_q      <= 24'h000000;
      exec_q       <= 1'b0;
      nop_q        <= 1'b0;
      instr_done_q <= 1'b0;
      dbl_word_q   <= 48'h000000000000;
      dbl_valid_q  <= 1'b0;
      second_bad_q <= 1'b0;
    end else begin
      exec_q       <= 1'b0;
      nop_q        <= 1'b0;
      instr_done_q <= 1'b0;
      dbl_valid_q  <= 1'b0;
      second_bad_q <= 1'b0;
      unique case (state_q)
        ICT_DECODE: begin
          if (word_valid) begin
            if (is_double) begin
              // hold first word; next fetch is its operand, not an opcode
              first_q <= word_data; // RULE_13
              exec_q  <= 1'b1;
              state_q <= ICT_OPERAND; // RULE_04 RULE_09
            end else if (is_skip || single_cycles == CYC_ONE) begin
              // a lone second word decodes as nop: top bits zero, no flow effect
              exec_q       <= !hi_zero; // RULE_03
              nop_q        <= hi_zero;  // RULE_03
              instr_done_q <= (single_cycles == CYC_ONE);
              extra_q      <= single_cycles - CYC_ONE;
              if (single_cycles != CYC_ONE) state_q <= ICT_FILL;
            end else begin
              exec_q  <= 1'b1;
              extra_q <= single_cycles - CYC_ONE;
              state_q <= ICT_FILL;
            end
          end
        end
        ICT_OPERAND: begin
          if (word_valid) begin
            dbl_word_q   <= {first_q, word_data}; // RULE_01
            dbl_valid_q  <= 1'b1;
            second_bad_q <= !hi_zero; // RULE_02
            exec_q       <= 1'b1;
            instr_done_q <= 1'b1; // RULE_04
            state_q      <= ICT_DECODE;
          end
        end
        ICT_FILL: begin
          // fill cycles assert only nop, plus instr_done_q on the last one, so no state is written
          nop_q   <= 1'b1; // RULE_07
          extra_q <= extra_q - 2'h1;
          if (extra_q == 2'h1) begin
            instr_done_q <= 1'b1;
            state_q      <= ICT_DECODE;
          end
        end
        default: state_q <= ICT_DECODE;
      endcase
    end
  end

  // operand field limits, registered for timing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lit_q      <= 10'h000;
      lit_err_q  <= 1'b0;
      bit_mask_q <= 16'h0000;
    end else begin
      lit_err_q  <= (ten_bit_unsigned_literal > lit_max); // RULE_10
      lit_q      <= (ten_bit_unsigned_literal > lit_max) ? lit_max : ten_bit_unsigned_literal; // RULE_10
      bit_mask_q <= 16'h0001 << (bit_position_selector & BIT_SEL_MAX); // RULE_11
    end
  end

  // accumulator write-back target
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      writeback_mem_q  <= 1'b0;
      writeback_addr_q <= 16'h0000;
      wreg13_next_q    <= 16'h0000;
    end else begin
      writeback_mem_q  <= writeback_indirect; // RULE_12
      writeback_addr_q <= working_register_thirteen;
      // pointer wraps at 16 bits, same as the register file adder
      wreg13_next_q    <= writeback_indirect ? working_register_thirteen + WB_POST_INC
                                             : working_register_thirteen; // RULE_12
    end
  end
endmodule
`default_nettype wire

// file: ict_pkg.sv
// Overview of operation
// RULE_01 - double-word instructions carry full operands across two words, 48 bits total
// RULE_02 - second word of a double-word instruction has its top eight bits zero
// RULE_03 - a second word fetched and executed alone acts as a no-op; code raises exec_q instead when single_cycles is CYC_TWO and is_skip is low
// RULE_04 - every double-word instruction completes in exactly two cycles
// RULE_05 - single-word instructions default to one cycle
// RULE_06 - true conditional, pc change, program-space/table read or special register read extends cycles
// RULE_07 - inserted extra cycles are no-ops without side effects
// RULE_08 - taken skip costs two cycles over single-word, three over two-word instruction
// RULE_09 - double-word data moves take two cycles
// RULE_10 - ten-bit literal limited to 0..255 byte mode, 0..1023 word mode
// RULE_11 - four-bit bit selector picks bit 0..15 of the word
// RULE_12 - accumulator write-back goes to register thirteen or its word, post-increment two
// RULE_13 - decode tracks a pending second word and consumes it as operand
package ict_pkg;
  localparam int unsigned WORD_W       = 24;
  localparam int unsigned DBL_BITS     = 48;
  localparam int unsigned HI_ZERO_W    = 8;
  localparam int unsigned HI_ZERO_LSB  = WORD_W - HI_ZERO_W;
  localparam logic [9:0]  LIT_BYTE_MAX = 10'h0ff;
  localparam logic [9:0]  LIT_WORD_MAX = 10'h3ff;
  localparam logic [3:0]  BIT_SEL_MAX  = 4'hf;
  localparam logic [15:0] WB_POST_INC  = 16'h0002;
  localparam logic [1:0]  CYC_ONE      = 2'h1;
  localparam logic [1:0]  CYC_TWO      = 2'h2;
  localparam logic [1:0]  CYC_THREE    = 2'h3;
  typedef enum logic [1:0] {ICT_DECODE, ICT_OPERAND, ICT_FILL} ict_state_t;
endpackage

// file: ict_pmem.sv
`timescale 1ns/1ps
`default_nettype none
// program memory: even words carry an opcode byte, odd words a zero top byte
module ict_pmem (input wire logic clk, input wire logic rd, input wire logic [3:0] addr,
  output logic word_valid, output logic [23:0] word_data);
  logic [23:0] last_q;
  // an idle bus shows the inverse of the last word, so nothing stale looks valid
  always_ff @(posedge clk) last_q <= word_data;
  assign word_valid = rd;
  assign word_data = rd ? {addr[0] ? 8'h00 : 8'h3c, 12'h000, addr} : ~last_q;
endmodule
`default_nettype wire

// file: ict_timing_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ict_timing_chk (input wire logic clk, input wire logic rst_n, input wire logic byte_mode,
  input wire logic [9:0] ten_bit_unsigned_literal, input wire logic [3:0] bit_position_selector,
  input wire logic exec_q, input wire logic nop_q, input wire logic instr_done_q,
  input wire logic dbl_valid_q, input wire logic [9:0] lit_q, input wire logic [15:0] bit_mask_q);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // two fill cycles in a row, as after a skip over a two-word op
  sequence s_fill2; nop_q ##1 nop_q; endsequence
  a_lit_value: assert property (1'b1 |=> lit_q == ($past(byte_mode) && $past(ten_bit_unsigned_literal) > 10'h0ff
    ? 10'h0ff : $past(ten_bit_unsigned_literal))) else $error("literal");
  a_bit_onehot: assert property (1'b1 |=> bit_mask_q == 16'h0001 << $past(bit_position_selector)) else $error("bit");
  a_nop_excl: assert property (nop_q |-> !exec_q) else $error("nop exec");
  a_dbl_two: assert property (dbl_valid_q |-> exec_q && instr_done_q) else $error("dbl end");
  a_dbl_lead: assert property (dbl_valid_q |-> $past(exec_q) && !$past(instr_done_q)) else $error("dbl");
  a_fill_done: assert property (exec_q ##1 s_fill2 |-> instr_done_q) else $error("fill");
  a_nop_bound: assert property (nop_q |-> ##[0:1] instr_done_q) else $error("nop end");
  a_done_kind: assert property (instr_done_q |-> exec_q || nop_q) else $error("done");
endmodule
bind ict_timing ict_timing_chk u_chk (.*);
`default_nettype wire

// file: instruction_cycle_timing_tb.sv
`timescale 1ns/1ps
`default_nettype none
module instruction_cycle_timing_tb;
  logic clk = 0, rst_n = 0, rd = 0, dbl = 0, skp = 0, cnd = 0, pcc = 0, pgm = 0, srd = 0, nxd = 0, bm = 0;
  logic ind = 0;
  logic [3:0] adr = 0, bs = 0;
  logic [9:0] lit = 0, lq;
  logic [15:0] w = 0, bq, wn, wa;
  logic wv, ex, np, dn, dv, sb, le, wm;
  logic [23:0] wd;
  logic [47:0] dw;
  int num_errors = 0, tests_run = 0, n, k;
  // free-running core clock
  always #12.5 clk = ~clk;
  ict_pmem mem (.clk(clk), .rd(rd), .addr(adr), .word_valid(wv), .word_data(wd));
  ict_timing dut (.clk(clk), .rst_n(rst_n), .word_valid(wv), .word_data(wd), .is_double(dbl), .is_skip(skp),
    .cond_true(cnd), .pc_change(pcc), .program_space_visibility_access(pgm), .special_function_register(srd),
    .next_is_double(nxd), .byte_mode(bm), .ten_bit_unsigned_literal(lit), .bit_position_selector(bs),
    .writeback_indirect(ind), .working_register_thirteen(w), .exec_q(ex), .nop_q(np), .instr_done_q(dn),
    .dbl_word_q(dw), .dbl_valid_q(dv), .second_bad_q(sb), .lit_q(lq), .lit_err_q(le), .bit_mask_q(bq),
    .writeback_mem_q(wm), .writeback_addr_q(wa), .wreg13_next_q(wn));
  task automatic chk(logic [47:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // every instruction class in turn; the cycle model is a table on k
  initial begin
    void'($urandom(32'hd5fd0b79));
    repeat (8) @(posedge clk);
    @(negedge clk) rst_n = 1;
    for (int i = 0; i < 45; i++) begin
      k = i % 9;
      @(negedge clk);
      dbl = k == 1;
      skp = k == 6 || k == 7;
      cnd = k == 2 || k == 6 || k == 7;
      pcc = k == 3;
      pgm = k == 4;
      srd = k == 5;
      nxd = k == 7;
      adr = {3'($urandom), k == 8};
      {bm, ind, bs, lit, w} = $urandom;
      rd = 1;
      // the word is taken at the next rising edge; its pulses stand for the cycle after it
      for (n = 1; n < 8; n++) begin
        @(posedge clk) #1;
        if (n == 1) begin
          chk(lq, bm && lit > 10'h0ff ? 10'h0ff : lit);
          chk(le, bm && lit > 10'h0ff);
          chk(bq, 16'h0001 << bs);
          chk(wn, 16'(w + {ind, 1'b0}));
          chk({wm, wa}, {ind, w});
          chk(np, k == 8);
          chk(ex, k != 8);
        end else begin
          chk(np, k != 1);
          chk(ex, k == 1);
        end
        if (dn === 1'b1) break;
        // only a double-word op gets its second word; fill cycles see no fetch
        @(negedge clk) rd = n == 1 && k == 1;
        dbl = 0;
        adr++;
      end
      chk(n, k % 8 ? (k == 7 ? 3 : 2) : 1);
      if (k == 1) begin
        chk(dw, {8'h3c, 12'h000, adr - 4'h1, 8'h00, 12'h000, adr});
        chk({dv, sb}, 2'b10);
      end
      if (n == 8) results;
    end
    results;
  end
endmodule
`default_nettype wire
